/* File: src/i2c_slave_cmd_pkg.sv */
// Constants, field layouts and types of the slave command and interrupt-enable block.
package i2c_slave_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0] OFS_ENABLE_SET = 8'h16;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1a;
    localparam logic [7:0] OFS_MATCH = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields.
    localparam int CTL_ACK_CHOICE = 18;
    localparam int CTL_CMD_LO = 16;
    localparam int CTL_SCHEME_LO = 14;
    localparam int CTL_AUTO_ACK = 10;
    localparam int CTL_GROUP = 9;
    localparam int CTL_SMART = 8;

    // Flag and enable vector positions, shared by flags and both enable registers.
    localparam int FLG_ERROR = 7;
    localparam int FLG_BYTE_DONE = 2;
    localparam int FLG_ADDR_HIT = 1;
    localparam int FLG_STOP = 0;
    localparam logic [7:0] FLG_USED = 8'h87;
    localparam logic [7:0] FLG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // Status register fields.
    localparam int STS_CLK_HOLD = 7;
    localparam int STS_DIR = 3;

    // Match register fields.
    localparam int MATCH_PRIMARY_LO = 0;
    localparam int MATCH_SECONDARY_LO = 16;
    localparam int ADDR_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Modes and commands.
    typedef enum logic [1:0] {
        MASKED_MATCH_SCHEME = 2'b00,
        DUAL_MATCH_SCHEME = 2'b01,
        RANGE_MATCH_SCHEME = 2'b10,
        RESERVED_MATCH_SCHEME = 2'b11
    } match_scheme_e;

    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_RESERVED = 2'b01,
        CMD_FINISH = 2'b10,
        CMD_CONTINUE = 2'b11
    } slave_cmd_e;

endpackage : i2c_slave_cmd_pkg

/* File: src/i2c_slave_cmd.sv */
// Command strobe, address matching and interrupt-enable logic of the bus slave.
//
// Behaviour
// - Command field 17:16 is a write-only strobe that always reads zero.
// - Action depends on command, pending byte or address flag, and direction.
// - Commands 2 and 3 clear byte-done, address-hit and stop flags; commands 0 and 1 clear none.
// - Command 2 after data in master write: acknowledge, then wait for start.
// - Command 2 after data in master read: wait for start, no acknowledge.
// - Command 3 in master write after address or data: acknowledge, receive next.
// - Command 3 after address in master read: acknowledge, then raise data flag.
// - Command 3 after data in master read: shift byte out, then take ACK/NACK.
// - Scheme 0 matches primary value with secondary value as don't-care mask.
// - Scheme 1 matches either primary or secondary value exactly.
// - Scheme 2 matches the inclusive range, primary is upper bound; 3 reserved.
// - Automatic address acknowledge on match when bit 10 is set.
// - Group command raises stop flag if addressed since previous stop.
// - Smart mode sends acknowledge when software reads the data byte.
// - Scheme, auto-ack, group and smart settings act directly on write.
// - Command field stays writable while the module is enabled.
// - Reserved control and enable bits read as zero.
// - Enables for error, byte-done, address-hit, stop at bits 7, 2, 1, 0.
// - Writing one to enable-clear register clears that enable.
// - Writing one to enable-set register sets that enable.
// - Both enable registers read the same enable vector.
// - Acknowledge choice zero sends ACK, one sends NACK.
// - Direction status holds the direction bit of the last matched address.
`timescale 1ns/1ps

module i2c_slave_cmd #(
    parameter int ADDR_W = i2c_slave_cmd_pkg::ADDR_W
) (
    // Clock, reset and clock enable.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Events from the bit-level bus engine, one cycle each.
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic addr_received,
    input wire logic [ADDR_W-1:0] addr_value,
    input wire logic addr_dir,
    input wire logic byte_done,
    input wire logic bus_error,
    input wire logic data_read,
    // Actions to the bus engine, one-cycle pulses, and levels.
    output logic addr_match,
    output logic ack_send,
    output logic ack_is_nack,
    output logic rx_next,
    output logic tx_byte,
    output logic wait_start,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Matching function.

    function automatic logic match_fn(input logic [1:0] scheme, input logic [ADDR_W-1:0] rx,
                                      input logic [ADDR_W-1:0] pri,
                                      input logic [ADDR_W-1:0] sec);
        logic hit;
        hit = 1'b0;
        unique case (scheme)
            i2c_slave_cmd_pkg::MASKED_MATCH_SCHEME: begin
                hit = ((rx ^ pri) & ~sec) == '0;
            end
            i2c_slave_cmd_pkg::DUAL_MATCH_SCHEME: begin
                hit = (rx == pri) || (rx == sec);
            end
            i2c_slave_cmd_pkg::RANGE_MATCH_SCHEME: begin
                hit = (rx <= pri) && (rx >= sec);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : match_fn

    ////////////////////////////////////////////////////////////////////////////
    // Software state.

    logic [1:0] scheme_r;
    logic auto_ack_r;
    logic group_r;
    logic smart_r;
    logic ack_choice_r;
    logic [7:0] enable_r;
    logic [ADDR_W-1:0] primary_r;
    logic [ADDR_W-1:0] secondary_r;

    // Block state.
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic dir_r;
    logic dir_nxt;
    logic hit_since_start_r;
    logic hit_since_stop_r;

    // Action next values.
    logic ack_nxt;
    logic rx_nxt;
    logic tx_nxt;
    logic wait_nxt;
    logic match_now;

    logic wr_ctl;
    logic [1:0] cmd_wr;

    assign wr_ctl = reg_wr && (reg_addr == i2c_slave_cmd_pkg::OFS_CONTROL);
    assign cmd_wr = reg_wdata[i2c_slave_cmd_pkg::CTL_CMD_LO +: 2];
    assign match_now = addr_received && match_fn(scheme_r, addr_value, primary_r, secondary_r);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // No enable gate on these writes: the command stays usable while running.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scheme_r <= 2'h0;
            auto_ack_r <= 1'b0;
            group_r <= 1'b0;
            smart_r <= 1'b0;
            ack_choice_r <= 1'b0;
        end else if (clk_en && wr_ctl) begin
            scheme_r <= reg_wdata[i2c_slave_cmd_pkg::CTL_SCHEME_LO +: 2];
            auto_ack_r <= reg_wdata[i2c_slave_cmd_pkg::CTL_AUTO_ACK];
            group_r <= reg_wdata[i2c_slave_cmd_pkg::CTL_GROUP];
            smart_r <= reg_wdata[i2c_slave_cmd_pkg::CTL_SMART];
            ack_choice_r <= reg_wdata[i2c_slave_cmd_pkg::CTL_ACK_CHOICE];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            primary_r <= '0;
            secondary_r <= '0;
        end else if (clk_en && reg_wr && (reg_addr == i2c_slave_cmd_pkg::OFS_MATCH)) begin
            primary_r <= reg_wdata[i2c_slave_cmd_pkg::MATCH_PRIMARY_LO +: ADDR_W];
            secondary_r <= reg_wdata[i2c_slave_cmd_pkg::MATCH_SECONDARY_LO +: ADDR_W];
        end
    end

    // One enable vector behind both the set and the clear address.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_r <= i2c_slave_cmd_pkg::ENABLE_RESET;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == i2c_slave_cmd_pkg::OFS_ENABLE_CLEAR) begin
                enable_r <= enable_r & ~(reg_wdata[7:0] & i2c_slave_cmd_pkg::FLG_USED);
            end else if (reg_addr == i2c_slave_cmd_pkg::OFS_ENABLE_SET) begin
                enable_r <= enable_r | (reg_wdata[7:0] & i2c_slave_cmd_pkg::FLG_USED);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, address events and flags.

    always_comb begin
        flags_nxt = flags_r;
        dir_nxt = dir_r;
        ack_nxt = 1'b0;
        rx_nxt = 1'b0;
        tx_nxt = 1'b0;
        wait_nxt = 1'b0;
        // Software clears come first so that hardware sets below win.
        if (reg_wr && (reg_addr == i2c_slave_cmd_pkg::OFS_FLAGS)) begin
            flags_nxt = flags_nxt & ~(reg_wdata[7:0] & i2c_slave_cmd_pkg::FLG_USED);
        end
        if (wr_ctl && (cmd_wr == i2c_slave_cmd_pkg::CMD_FINISH ||
                       cmd_wr == i2c_slave_cmd_pkg::CMD_CONTINUE)) begin
            flags_nxt[i2c_slave_cmd_pkg::FLG_BYTE_DONE] = 1'b0;
            flags_nxt[i2c_slave_cmd_pkg::FLG_ADDR_HIT] = 1'b0;
            flags_nxt[i2c_slave_cmd_pkg::FLG_STOP] = 1'b0;
            // Address phase has priority if both flags are somehow pending.
            if (flags_r[i2c_slave_cmd_pkg::FLG_ADDR_HIT]) begin
                if (cmd_wr == i2c_slave_cmd_pkg::CMD_CONTINUE) begin
                    ack_nxt = 1'b1;
                    if (!dir_r) begin
                        rx_nxt = 1'b1;
                    end else begin
                        flags_nxt[i2c_slave_cmd_pkg::FLG_BYTE_DONE] = 1'b1;
                    end
                end
            end else if (flags_r[i2c_slave_cmd_pkg::FLG_BYTE_DONE]) begin
                if (cmd_wr == i2c_slave_cmd_pkg::CMD_FINISH) begin
                    ack_nxt = !dir_r;
                    wait_nxt = 1'b1;
                end else if (!dir_r) begin
                    ack_nxt = 1'b1;
                    rx_nxt = 1'b1;
                end else begin
                    tx_nxt = 1'b1;
                end
            end
        end
        // Smart mode: reading the received byte acknowledges it.
        if (smart_r && data_read && !dir_r && flags_r[i2c_slave_cmd_pkg::FLG_BYTE_DONE]) begin
            flags_nxt[i2c_slave_cmd_pkg::FLG_BYTE_DONE] = 1'b0;
            ack_nxt = 1'b1;
            rx_nxt = 1'b1;
        end
        if (match_now) begin
            dir_nxt = addr_dir;
            if (auto_ack_r) begin
                ack_nxt = 1'b1;
                if (!addr_dir) begin
                    rx_nxt = 1'b1;
                end else begin
                    flags_nxt[i2c_slave_cmd_pkg::FLG_BYTE_DONE] = 1'b1;
                end
            end else begin
                flags_nxt[i2c_slave_cmd_pkg::FLG_ADDR_HIT] = 1'b1;
            end
        end
        if (byte_done) begin
            flags_nxt[i2c_slave_cmd_pkg::FLG_BYTE_DONE] = 1'b1;
        end
        if (bus_error) begin
            flags_nxt[i2c_slave_cmd_pkg::FLG_ERROR] = 1'b1;
        end
        if (stop_seen && (group_r ? hit_since_stop_r : hit_since_start_r)) begin
            flags_nxt[i2c_slave_cmd_pkg::FLG_STOP] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_r <= i2c_slave_cmd_pkg::FLG_RESET;
            dir_r <= 1'b0;
        end else if (clk_en) begin
            flags_r <= flags_nxt;
            dir_r <= dir_nxt;
        end
    end

    // Addressed-since trackers; a match in the same cycle as a stop belongs to
    // the next transaction, so the set wins.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hit_since_start_r <= 1'b0;
            hit_since_stop_r <= 1'b0;
        end else if (clk_en) begin
            if (match_now) begin
                hit_since_start_r <= 1'b1;
                hit_since_stop_r <= 1'b1;
            end else begin
                if (start_seen || stop_seen) begin
                    hit_since_start_r <= 1'b0;
                end
                if (stop_seen) begin
                    hit_since_stop_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the bus engine and interrupt.

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_send <= 1'b0;
            ack_is_nack <= 1'b0;
            rx_next <= 1'b0;
            tx_byte <= 1'b0;
            wait_start <= 1'b0;
            addr_match <= 1'b0;
        end else if (clk_en) begin
            ack_send <= ack_nxt;
            if (ack_nxt) begin
                // A command word carries its own choice in the same write.
                ack_is_nack <= wr_ctl ? reg_wdata[i2c_slave_cmd_pkg::CTL_ACK_CHOICE]
                                      : ack_choice_r;
            end
            rx_next <= rx_nxt;
            tx_byte <= tx_nxt;
            wait_start <= wait_nxt;
            addr_match <= match_now;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(flags_nxt & enable_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, data valid the cycle after the read strobe.

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    i2c_slave_cmd_pkg::OFS_CONTROL: begin
                        reg_rdata[i2c_slave_cmd_pkg::CTL_ACK_CHOICE] <= ack_choice_r;
                        reg_rdata[i2c_slave_cmd_pkg::CTL_CMD_LO +: 2] <= 2'h0;
                        reg_rdata[i2c_slave_cmd_pkg::CTL_SCHEME_LO +: 2] <= scheme_r;
                        reg_rdata[i2c_slave_cmd_pkg::CTL_AUTO_ACK] <= auto_ack_r;
                        reg_rdata[i2c_slave_cmd_pkg::CTL_GROUP] <= group_r;
                        reg_rdata[i2c_slave_cmd_pkg::CTL_SMART] <= smart_r;
                    end
                    i2c_slave_cmd_pkg::OFS_ENABLE_CLEAR,
                    i2c_slave_cmd_pkg::OFS_ENABLE_SET: begin
                        reg_rdata[7:0] <= enable_r & i2c_slave_cmd_pkg::FLG_USED;
                    end
                    i2c_slave_cmd_pkg::OFS_FLAGS: begin
                        reg_rdata[7:0] <= flags_r;
                    end
                    i2c_slave_cmd_pkg::OFS_STATUS: begin
                        reg_rdata[i2c_slave_cmd_pkg::STS_DIR] <= dir_r;
                        reg_rdata[i2c_slave_cmd_pkg::STS_CLK_HOLD] <=
                            flags_r[i2c_slave_cmd_pkg::FLG_BYTE_DONE] |
                            flags_r[i2c_slave_cmd_pkg::FLG_ADDR_HIT];
                    end
                    i2c_slave_cmd_pkg::OFS_MATCH: begin
                        reg_rdata[i2c_slave_cmd_pkg::MATCH_PRIMARY_LO +: ADDR_W] <= primary_r;
                        reg_rdata[i2c_slave_cmd_pkg::MATCH_SECONDARY_LO +: ADDR_W] <=
                            secondary_r;
                    end
                    default: begin
                        reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule : i2c_slave_cmd

/* File: test/i2c_slave_cmd_asserts.sv */
// Port checker of the slave command, matching and interrupt-enable block.
`timescale 1ns/1ps

module i2c_slave_cmd_asserts (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Bus engine events.
    input wire logic addr_received,
    input wire logic data_read,
    // Bus engine actions.
    input wire logic addr_match,
    input wire logic ack_send,
    input wire logic ack_is_nack,
    input wire logic rx_next,
    input wire logic tx_byte,
    input wire logic wait_start
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic cmd_wr;
    assign cmd_wr = reg_wr && reg_addr == i2c_slave_cmd_pkg::OFS_CONTROL;
    ////////////////////////////////////////
    ctl_read_zero_a: assert property ($past(reg_rd && reg_addr == 8'h04) |->
        (reg_rdata & 32'hfffb_38ff) == 32'h0) else $error("control reads reserved bits");
    en_read_zero_a: assert property ($past(reg_rd && reg_addr inside {8'h14, 8'h16}) |->
        (reg_rdata & 32'hffff_ff78) == 32'h0) else $error("enable reads reserved bits");
    match_cause_a: assert property (addr_match |-> $past(addr_received))
        else $error("match without address");
    ack_cause_a: assert property (ack_send |-> $past(cmd_wr && reg_wdata[17]) ||
        $past(addr_received) || $past(data_read)) else $error("ack without cause");
    nack_pair_a: assert property (ack_send && $past(cmd_wr) |->
        ack_is_nack == $past(reg_wdata[18])) else $error("ack polarity wrong");
    rx_after_ack_a: assert property (rx_next |-> ack_send)
        else $error("receive without ack");
    tx_cause_a: assert property (tx_byte |-> !ack_send &&
        $past(cmd_wr && reg_wdata[17:16] == 2'b11)) else $error("shift out without command");
    finish_cause_a: assert property (wait_start |-> !rx_next &&
        $past(cmd_wr && reg_wdata[17:16] == 2'b10)) else $error("wait without command");
    cmd_idle_a: assert property (cmd_wr && !reg_wdata[17] && !addr_received && !data_read
        |=> !(ack_send || rx_next || tx_byte || wait_start)) else $error("idle command acted");
    cover property (tx_byte);
    cover property (wait_start && !ack_send);
    cover property (addr_match && ack_send);
endmodule : i2c_slave_cmd_asserts

bind i2c_slave_cmd i2c_slave_cmd_asserts chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .addr_received(addr_received), .data_read(data_read),
    .addr_match(addr_match), .ack_send(ack_send), .ack_is_nack(ack_is_nack),
    .rx_next(rx_next), .tx_byte(tx_byte), .wait_start(wait_start));

/* File: test/bus_engine_model.sv */
// Behavioural bus engine that turns bench requests into one-cycle event pulses.
`timescale 1ns/1ps

module bus_engine_model (
    // Clock.
    input wire logic sys_clk,
    // Events towards the slave block.
    output logic start_seen,
    output logic stop_seen,
    output logic addr_received,
    output logic [6:0] addr_value,
    output logic addr_dir,
    output logic byte_done,
    output logic bus_error,
    output logic data_read
);
    initial begin
        {data_read, bus_error, byte_done, addr_received, stop_seen, start_seen} = 6'h00;
        addr_value = 7'h55;
        addr_dir = 1'b0;
    end
    // Address and direction mean nothing outside the address pulse, so they then show
    // the inverse of the last value instead of holding it.
    task automatic ev(input logic [5:0] k, input logic [6:0] a, input logic d);
        {data_read, bus_error, byte_done, addr_received, stop_seen, start_seen} <= k;
        addr_value <= a;
        addr_dir <= d;
        @(posedge sys_clk);
        {data_read, bus_error, byte_done, addr_received, stop_seen, start_seen} <= 6'h00;
        addr_value <= ~a;
        addr_dir <= ~d;
        #1;
    endtask : ev
endmodule : bus_engine_model

/* File: test/i2c_slave_cmd_tb_top.sv */
// Self-checking bench of the slave command, matching and interrupt-enable block.
`timescale 1ns/1ps

module i2c_slave_cmd_tb_top;
    localparam logic [7:0] CTL = i2c_slave_cmd_pkg::OFS_CONTROL;
    localparam logic [7:0] FLG = i2c_slave_cmd_pkg::OFS_FLAGS;
    localparam logic [7:0] STS = i2c_slave_cmd_pkg::OFS_STATUS;
    localparam logic [7:0] MAT = i2c_slave_cmd_pkg::OFS_MATCH;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic start_seen, stop_seen, addr_received, addr_dir, byte_done, bus_error, data_read;
    logic [6:0] addr_value;
    logic addr_match, ack_send, ack_is_nack, rx_next, tx_byte, wait_start, irq;
    logic [7:0] ofs [7] = '{8'h04, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h20, 8'h30};
    int error_cnt = 0;
    int checks_done = 0;
    always #50 sys_clk = ~sys_clk;
    i2c_slave_cmd dut (.sys_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .start_seen, .stop_seen, .addr_received, .addr_value, .addr_dir,
        .byte_done, .bus_error, .data_read, .addr_match, .ack_send, .ack_is_nack,
        .rx_next, .tx_byte, .wait_start, .irq);
    bus_engine_model eng (.sys_clk, .start_seen, .stop_seen, .addr_received, .addr_value,
        .addr_dir, .byte_done, .bus_error, .data_read);
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk
    // Tasks start and end 1 ns after a rising edge, so strobes are always one cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(nm, exp, rv);
    endtask : rc
    function automatic logic [31:0] pulses();
        return {28'h0, ack_send, rx_next, tx_byte, wait_start};
    endfunction : pulses
    task automatic tm(input logic [1:0] s, input logic [6:0] p, input logic [6:0] q,
                      input logic [6:0] a, input logic e);
        wr(MAT, {9'h0, q, 9'h0, p});
        wr(CTL, {16'h0, s, 14'h0});
        wr(FLG, 32'hff);
        eng.ev(6'h04, a, 1'b0);
        chk("address match", {31'h0, e}, {31'h0, addr_match});
        rc("address hit flag", FLG, {30'h0, e, 1'b0});
    endtask : tm
    // A stop after each match sets the stop flag, so commands 2 and 3 must clear it along with the pending flag.
    task automatic tc(input logic k, input logic d, input logic [1:0] c, input logic n,
                      input logic [3:0] ep, input logic [7:0] ef);
        wr(CTL, 32'h0);
        wr(FLG, 32'hff);
        eng.ev(6'h04, 7'h40, d);
        if (k) begin
            wr(FLG, 32'hff);
            eng.ev(6'h08, 7'h00, 1'b0);
        end
        eng.ev(6'h02, 7'h00, 1'b0);
        wr(CTL, {13'h0, n, c, 16'h0});
        chk("command pulses", {28'h0, ep}, pulses());
        if (ep[3]) chk("ack polarity", {31'h0, n}, {31'h0, ack_is_nack});
        rc("flags after command", FLG, {24'h0, ef});
    endtask : tc
    ////////////////////////////////////////
    initial begin
        #2000000;
        $display("timeout");
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        foreach (ofs[i]) rc("reset value", ofs[i], 32'h0);
        wr(8'h30, 32'hffff_ffff);
        rc("unmapped", 8'h30, 32'h0);
        wr(8'h16, 32'hff);
        rc("enables via clear", 8'h14, 32'h87);
        wr(8'h14, 32'h05);
        rc("enables via set", 8'h16, 32'h82);
        wr(8'h14, 32'hff);
        wr(CTL, 32'hffff_ffff);
        chk("idle command pulses", 32'h0, pulses());
        rc("control read", CTL, 32'h0004_c700);
        $display("test registers done");
        tm(2'h0, 7'h2a, 7'h03, 7'h29, 1'b1);
        tm(2'h0, 7'h2a, 7'h03, 7'h2e, 1'b0);
        tm(2'h1, 7'h10, 7'h20, 7'h20, 1'b1);
        tm(2'h1, 7'h10, 7'h20, 7'h10, 1'b1);
        tm(2'h1, 7'h10, 7'h20, 7'h30, 1'b0);
        tm(2'h2, 7'h40, 7'h30, 7'h40, 1'b1);
        tm(2'h2, 7'h40, 7'h30, 7'h30, 1'b1);
        tm(2'h2, 7'h40, 7'h30, 7'h41, 1'b0);
        tm(2'h2, 7'h40, 7'h30, 7'h2f, 1'b0);
        tm(2'h3, 7'h40, 7'h30, 7'h40, 1'b0);
        $display("test matching done");
        tc(1'b0, 1'b0, 2'h3, 1'b1, 4'hc, 8'h00);
        tc(1'b0, 1'b1, 2'h3, 1'b0, 4'h8, 8'h04);
        tc(1'b1, 1'b0, 2'h2, 1'b1, 4'h9, 8'h00);
        tc(1'b1, 1'b1, 2'h2, 1'b0, 4'h1, 8'h00);
        tc(1'b1, 1'b0, 2'h3, 1'b0, 4'hc, 8'h00);
        tc(1'b1, 1'b1, 2'h3, 1'b0, 4'h2, 8'h00);
        tc(1'b0, 1'b0, 2'h1, 1'b0, 4'h0, 8'h03);
        tc(1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 8'h03);
        wr(FLG, 32'hff);
        eng.ev(6'h04, 7'h40, 1'b1);
        rc("status", STS, 32'h88);
        $display("test commands done");
        wr(CTL, 32'h0400);
        wr(FLG, 32'hff);
        eng.ev(6'h04, 7'h40, 1'b0);
        chk("auto ack pulses", 32'hc, pulses());
        rc("auto ack flags", FLG, 32'h0);
        wr(CTL, 32'h0004_0100);
        eng.ev(6'h04, 7'h40, 1'b0);
        wr(FLG, 32'hff);
        eng.ev(6'h08, 7'h00, 1'b0);
        eng.ev(6'h20, 7'h00, 1'b0);
        chk("smart pulses", 32'hc, pulses());
        chk("smart polarity", 32'h1, {31'h0, ack_is_nack});
        rc("smart flags", FLG, 32'h0);
        for (int g = 0; g < 2; g++) begin
            wr(CTL, {22'h0, g[0], 9'h0});
            wr(FLG, 32'hff);
            eng.ev(6'h04, 7'h40, 1'b0);
            eng.ev(6'h01, 7'h00, 1'b0);
            eng.ev(6'h02, 7'h00, 1'b0);
            rc("stop flag", FLG, {30'h0, 1'b1, g[0]});
        end
        $display("test modes done");
        wr(8'h16, 32'h82);
        wr(FLG, 32'hff);
        chk("irq idle", 32'h0, {31'h0, irq});
        eng.ev(6'h10, 7'h00, 1'b0);
        chk("irq on error", 32'h1, {31'h0, irq});
        wr(8'h14, 32'h80);
        rc("error flag", FLG, 32'h80);
        chk("irq masked", 32'h0, {31'h0, irq});
        // A write taken while the clock enable is low must leave no trace.
        clk_en <= 1'b0;
        wr(8'h16, 32'hff);
        clk_en <= 1'b1;
        rc("frozen enables", 8'h14, 32'h02);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        rc("enables after reset", 8'h16, 32'h0);
        rc("flags after reset", FLG, 32'h0);
        $display("test interrupts done");
        print_verdict();
    end
endmodule : i2c_slave_cmd_tb_top
